//--- design/msw_access.sv
// access engine: decoded register queries onto 32-bit user variables and display values
`timescale 1ns/1ns
`default_nettype none
module msw_access (
    input wire logic mclk,
    input wire logic reset_n,
    input wire msw_pkg::msw_cfg_s cfg,
    input wire msw_pkg::msw_query_s query,
    output msw_pkg::msw_answer_s answer,
    input wire logic [msw_pkg::NUM_VARS-1:0][31:0] display_values,
    output logic [msw_pkg::NUM_VARS-1:0][31:0] user_vars,
    input wire logic rs485_rx_pin,
    output logic rx_line,
    input wire logic tx_line,
    input wire logic tx_active,
    output logic rs485_tx_pin,
    output logic rs485_de
);
    msw_pkg::msw_pend_e state;
    msw_pkg::msw_pend_e next_state;
    msw_pkg::msw_answer_s next_answer;
    logic [7:0] pend_func;
    logic [msw_pkg::VAR_IDX_W-1:0] pend_var;
    logic pend_hi;
    logic [15:0] staged;
    logic [31:0] snap;
    logic [31:0] next_snap;
    logic [15:0] next_staged;
    logic [15:0] idx_full;
    logic [15:0] sub;
    logic [msw_pkg::VAR_IDX_W-1:0] idx;
    logic [7:0] qty;
    logic [31:0] cur;
    logic wide;
    logic in_range;
    logic half_hi;
    logic func_ok;
    logic is_read;
    logic match;
    logic wr_en;
    logic [31:0] wr_data;
    logic start_wr;
    logic complete_wr;
    logic complete_rd;
    logic rx_meta;
    logic rx_s2;
    logic rx_s3;

    msw_var_store u_store (
        .mclk(mclk),
        .reset_n(reset_n),
        .wr_en(wr_en),
        .wr_idx(idx),
        .wr_data(wr_data),
        .vars(user_vars)
    );

    always_comb begin
        idx_full = query.reg_addr / msw_pkg::VAR_STRIDE;
        sub = query.reg_addr % msw_pkg::VAR_STRIDE;
        idx = idx_full[msw_pkg::VAR_IDX_W-1:0];
        in_range = idx_full < 16'(msw_pkg::NUM_VARS);
        wide = (cfg.data_type == msw_pkg::MSW_FLOAT32) ||
               (cfg.data_type == msw_pkg::MSW_LONG32);
        half_hi = (sub == msw_pkg::SUB_BASE) ^ cfg.word_swap;
        func_ok = (query.func == msw_pkg::FC_READ_HOLD) || (query.func == msw_pkg::FC_READ_INPUT) ||
                  (query.func == msw_pkg::FC_WRITE_SINGLE) || (query.func == msw_pkg::FC_WRITE_MULTI);
        is_read = (query.func == msw_pkg::FC_READ_HOLD) || (query.func == msw_pkg::FC_READ_INPUT);
        // display values sit only behind the read-input code, so nothing can write them
        cur = (query.func == msw_pkg::FC_READ_INPUT) ? display_values[idx] : user_vars[idx];
        qty = (query.func == msw_pkg::FC_WRITE_SINGLE) ? 8'h01 : query.quantity;
        match = (state != msw_pkg::MSW_IDLE) && (pend_func == query.func) &&
                (pend_var == idx) && (pend_hi != half_hi);
        next_answer = '0;
        next_answer.valid = query.valid;
        next_answer.quantity = qty;
        next_state = state;
        next_snap = snap;
        next_staged = staged;
        wr_en = 1'b0;
        wr_data = msw_pkg::VAR_RESET;
        start_wr = 1'b0;
        complete_wr = 1'b0;
        complete_rd = 1'b0;
        if (query.valid) begin
            // any query that does not finish the pending pair starts afresh
            next_state = msw_pkg::MSW_IDLE;
            if (!func_ok) begin
                next_answer.exception = msw_pkg::EXC_ILL_FUNC;
            end else if (!in_range || (sub > msw_pkg::SUB_NEXT) || (!wide && sub != msw_pkg::SUB_BASE)) begin
                next_answer.exception = msw_pkg::EXC_ILL_ADDR;
            end else if ((qty == 8'h00) || (qty > 8'h02)) begin
                next_answer.exception = msw_pkg::EXC_ILL_VALUE;
            end else if ((qty == 8'h02) && (!wide || sub != msw_pkg::SUB_BASE)) begin
                next_answer.exception = msw_pkg::EXC_ILL_ADDR;
            end else if (qty == 8'h02) begin
                // both halves in one transaction, first register in the upper word
                if (is_read) begin
                    next_answer.rdata = cfg.word_swap ? {cur[15:0], cur[31:16]} : cur;
                end else begin
                    wr_en = 1'b1;
                    wr_data = cfg.word_swap ? {query.wdata[15:0], query.wdata[31:16]} : query.wdata;
                end
            end else if (!wide) begin
                if (is_read) begin
                    next_answer.rdata = {16'h0000, cur[15:0]};
                end else begin
                    wr_en = 1'b1;
                    wr_data = (cfg.data_type == msw_pkg::MSW_INT16) ?
                              {{16{query.wdata[15]}}, query.wdata[15:0]} :
                              {16'h0000, query.wdata[15:0]};
                end
            end else if (is_read) begin
                if (match && state == msw_pkg::MSW_HALF_READ) begin
                    complete_rd = 1'b1;
                    next_answer.rdata = {16'h0000, half_hi ? snap[31:16] : snap[15:0]};
                end else begin
                    next_snap = cur;
                    next_state = msw_pkg::MSW_HALF_READ;
                    next_answer.rdata = {16'h0000, half_hi ? cur[31:16] : cur[15:0]};
                end
            end else begin
                if (match && state == msw_pkg::MSW_HALF_WRITE) begin
                    complete_wr = 1'b1;
                    wr_en = 1'b1;
                    wr_data = half_hi ? {query.wdata[15:0], staged} : {staged, query.wdata[15:0]};
                end else begin
                    // staging only; the stored value keeps its old content if the pair breaks
                    start_wr = 1'b1;
                    next_staged = query.wdata[15:0];
                    next_state = msw_pkg::MSW_HALF_WRITE;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            answer <= '0;
        end else begin
            answer <= next_answer;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= msw_pkg::MSW_IDLE;
            pend_func <= 8'h00;
            pend_var <= '0;
            pend_hi <= 1'b0;
            staged <= msw_pkg::HALF_RESET;
            snap <= msw_pkg::VAR_RESET;
        end else begin
            state <= next_state;
            staged <= next_staged;
            snap <= next_snap;
            if (query.valid) begin
                pend_func <= query.func;
                pend_var <= idx;
                pend_hi <= half_hi;
            end
        end
    end

    // three-stage receiver sync; the line only moves when the last two stages agree
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_meta <= msw_pkg::RX_IDLE;
            rx_s2 <= msw_pkg::RX_IDLE;
            rx_s3 <= msw_pkg::RX_IDLE;
            rx_line <= msw_pkg::RX_IDLE;
        end else begin
            rx_meta <= rs485_rx_pin;
            rx_s2 <= rx_meta;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) begin
                rx_line <= rx_s2;
            end
        end
    end

    // driver released whenever the framer is not sending, so other nodes may talk
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rs485_tx_pin <= msw_pkg::TX_IDLE;
            rs485_de <= 1'b0;
        end else begin
            rs485_tx_pin <= tx_active ? tx_line : msw_pkg::TX_IDLE;
            rs485_de <= tx_active;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_answer_next_cycle: assert property (query.valid |=> answer.valid)
        else $error("answer missing one cycle after query");
    a_half_write_held: assert property (start_wr |=> user_vars == $past(user_vars))
        else $error("first half write changed a variable");
    a_second_half_commit: assert property (complete_wr |=>
        user_vars[$past(idx)] == $past(wr_data) && state == msw_pkg::MSW_IDLE)
        else $error("second half did not commit the pair");
    a_second_read_snap: assert property (complete_rd |=>
        answer.rdata[15:0] == ($past(half_hi) ? $past(snap[31:16]) : $past(snap[15:0])))
        else $error("second half not served from snapshot");
    a_either_order_done: assert property ((query.valid && match && wide && func_ok &&
        in_range && qty == 8'h01 && sub <= msw_pkg::SUB_NEXT) |=> state == msw_pkg::MSW_IDLE)
        else $error("matching other half did not close the pair");
    a_func_change_drop: assert property ((query.valid && state != msw_pkg::MSW_IDLE &&
        query.func != pend_func) |-> !complete_wr && !complete_rd)
        else $error("pair completed across function codes");
    a_abandon_keeps: assert property ((state == msw_pkg::MSW_HALF_WRITE && query.valid &&
        !match && !(wr_en && idx == pend_var)) |=>
        user_vars[$past(pend_var)] == $past(user_vars[pend_var]))
        else $error("abandoned half write touched a variable");
    a_short_addr_exc: assert property ((query.valid && !wide && func_ok && in_range &&
        sub == msw_pkg::SUB_NEXT) |=> answer.exception == msw_pkg::EXC_ILL_ADDR)
        else $error("base plus one in 16-bit mode not refused");
    a_span_refused: assert property ((query.valid && func_ok && qty > 8'h01 &&
        sub != msw_pkg::SUB_BASE) |=> answer.exception != msw_pkg::EXC_NONE)
        else $error("multi-register access spanning variables accepted");
    a_display_read_only: assert property ((query.valid && query.func == msw_pkg::FC_READ_INPUT)
        |=> user_vars == $past(user_vars))
        else $error("read-input query wrote a variable");
    a_single_write16: assert property ((query.valid && !wide && query.func == msw_pkg::FC_WRITE_SINGLE
        && in_range && sub == msw_pkg::SUB_BASE) |=>
        user_vars[$past(idx)][15:0] == $past(query.wdata[15:0]))
        else $error("16-bit single write not stored");
    a_driver_enable: assert property ($rose(tx_active) |=> rs485_de ##1 (rs485_de == $past(tx_active)))
        else $error("driver enable does not follow transmit");

    c_split_write: cover property (start_wr ##[1:8] complete_wr);
    c_split_read: cover property (complete_rd);
    c_pair_broken: cover property (state == msw_pkg::MSW_HALF_WRITE && query.valid && !match);
    c_short_exc: cover property (answer.valid && answer.exception == msw_pkg::EXC_ILL_ADDR);
endmodule
`default_nettype wire

//--- design/msw_pkg.sv
// constants and types for split 32-bit register access over a 16-bit register protocol
// Function
// - In a 32-bit mode the master may reach a variable's two halves in two transactions, at the base address and at base plus one.
// - Display values are read only, and in a 32-bit mode they may be read as two halves at the base and at base plus one.
// - The first half of a split write is staged, and the stored value changes only when the second half arrives.
// - A split read snapshots the whole value at the first half and serves the second half from that snapshot.
// - The two halves are accepted in either order.
// - A pending half access is dropped and a fresh one begins on a different function code, the same half again or another variable.
// - In a 16-bit mode function codes 03, 04 and 16 serve one register at the base address carrying the whole value.
// - In a 32-bit mode a variable may be written as two code 06 writes, one at the base and one at base plus one.
// - In a 16-bit mode a variable is written by one code 06 write to its base address.
// - The serial port has one balanced receiver and one driver that can be switched off.
// - A configuration input selects the data type and the order of the halves of 32-bit types.
// - In a 16-bit mode an access to base plus one answers with an illegal data address exception.
// - Variables lie 10 registers apart, so a multi-register access never reaches more than one variable.
package msw_pkg;
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
    localparam int NUM_VARS = 16;
    localparam int VAR_IDX_W = 4;
    localparam logic [15:0] VAR_STRIDE = 16'h000A;
    localparam logic [15:0] SUB_BASE = 16'h0000;
    localparam logic [15:0] SUB_NEXT = 16'h0001;
    localparam logic [31:0] VAR_RESET = 32'h0000_0000;
    localparam logic [15:0] HALF_RESET = 16'h0000;
    localparam logic RX_IDLE = 1'b1;
    localparam logic TX_IDLE = 1'b1;

    typedef enum logic [1:0] {MSW_FLOAT32, MSW_LONG32, MSW_INT16, MSW_UINT16} msw_type_e;
    typedef enum logic [1:0] {MSW_IDLE, MSW_HALF_WRITE, MSW_HALF_READ} msw_pend_e;

    typedef struct packed {
        msw_type_e data_type;
        logic word_swap;
    } msw_cfg_s;

    typedef struct packed {
        logic valid;
        logic [7:0] func;
        logic [15:0] reg_addr;
        logic [7:0] quantity;
        logic [31:0] wdata;
    } msw_query_s;

    typedef struct packed {
        logic valid;
        logic [7:0] exception;
        logic [7:0] quantity;
        logic [31:0] rdata;
    } msw_answer_s;
endpackage

//--- design/msw_var_store.sv
// flip-flop store of the 32-bit user variables
`timescale 1ns/1ns
`default_nettype none
module msw_var_store (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [msw_pkg::VAR_IDX_W-1:0] wr_idx,
    input wire logic [31:0] wr_data,
    output logic [msw_pkg::NUM_VARS-1:0][31:0] vars
);
    genvar i;
    generate
        for (i = 0; i < msw_pkg::NUM_VARS; i++) begin : g_var
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    vars[i] <= msw_pkg::VAR_RESET;
                end else if (wr_en && (wr_idx == (msw_pkg::VAR_IDX_W)'(i))) begin
                    vars[i] <= wr_data;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- tb/msw_master_model.sv
// register-protocol master model: issues decoded queries and drives the receive pin
`timescale 1ns/1ns
`default_nettype none
module msw_master_model (
    input wire logic mclk,
    input wire msw_pkg::msw_answer_s answer,
    output msw_pkg::msw_query_s query,
    output logic rs485_rx_pin,
    input wire logic rs485_tx_pin,
    input wire logic rs485_de,
    output logic bus_level
);
    initial begin
        query = '0;
        rs485_rx_pin = 1'b1;
    end
    // idle bus is biased to mark when the device releases its driver
    assign bus_level = rs485_de ? rs485_tx_pin : 1'b1;
    // one query, answer taken before the next query, nothing sent in between
    task automatic send(input msw_pkg::msw_query_s q, output msw_pkg::msw_answer_s a);
        @(posedge mclk);
        query <= q;
        @(posedge mclk);
        query <= '0;
        @(negedge mclk);
        a = answer;
    endtask
    task automatic drive_line(input logic b);
        @(posedge mclk);
        rs485_rx_pin <= b;
    endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the split-word access engine
`timescale 1ns/1ns
`default_nettype none
module tb;
    typedef struct {
        logic [2:0] cf; logic [7:0] fc; logic [15:0] ad; logic [7:0] qt; logic [31:0] wd;
        logic [7:0] ex; logic [31:0] rd; logic ck; logic [3:0] ix; logic [31:0] vv;
    } msw_row_s;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    msw_pkg::msw_cfg_s cfg = '0;
    msw_pkg::msw_query_s query;
    msw_pkg::msw_answer_s answer, ans;
    logic [msw_pkg::NUM_VARS-1:0][31:0] display_values;
    logic [msw_pkg::NUM_VARS-1:0][31:0] user_vars;
    logic rs485_rx_pin, rx_line, rs485_tx_pin, rs485_de, bus_level;
    logic tx_line = 1'b1;
    logic tx_active = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    msw_row_s rows[$];
    always #20 mclk = ~mclk;
    msw_access msw_access_i (.mclk(mclk), .reset_n(reset_n), .cfg(cfg), .query(query),
        .answer(answer), .display_values(display_values), .user_vars(user_vars),
        .rs485_rx_pin(rs485_rx_pin), .rx_line(rx_line), .tx_line(tx_line),
        .tx_active(tx_active), .rs485_tx_pin(rs485_tx_pin), .rs485_de(rs485_de));
    msw_master_model msw_master_model_i (.mclk(mclk), .answer(answer), .query(query),
        .rs485_rx_pin(rs485_rx_pin), .rs485_tx_pin(rs485_tx_pin), .rs485_de(rs485_de),
        .bus_level(bus_level));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic add(input logic [2:0] cf, input logic [7:0] fc, input logic [15:0] ad,
            input logic [7:0] qt, input logic [31:0] wd, input logic [7:0] ex,
            input logic [31:0] rd, input logic ck, input logic [3:0] ix, input logic [31:0] vv);
        rows.push_back('{cf, fc, ad, qt, wd, ex, rd, ck, ix, vv});
    endtask
    task automatic ask(input logic [7:0] fc, input logic [15:0] ad, input logic [7:0] qt);
        msw_master_model_i.send('{1'b1, fc, ad, qt, 32'h0000_0000}, ans);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        // long enough for every row plus the pin and reset tests, with margin
        repeat (5000) @(posedge mclk);
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        for (int i = 0; i < msw_pkg::NUM_VARS; i++) begin
            display_values[i] = {8'hD0, 8'(i), 8'hC0, 8'(i)};
        end
        add(3'h2, 8'h06, 16'd0, 8'h01, 32'h1234, 8'h00, 0, 1, 0, 32'h0);
        add(3'h2, 8'h06, 16'd1, 8'h01, 32'h5678, 8'h00, 0, 1, 0, 32'h1234_5678);
        add(3'h2, 8'h03, 16'd1, 8'h01, 0, 8'h00, 32'h5678, 0, 0, 0);
        add(3'h2, 8'h03, 16'd0, 8'h01, 0, 8'h00, 32'h1234, 0, 0, 0);
        add(3'h0, 8'h04, 16'd20, 8'h01, 0, 8'h00, 32'hD002, 0, 0, 0);
        add(3'h0, 8'h04, 16'd21, 8'h01, 0, 8'h00, 32'hC002, 0, 0, 0);
        add(3'h2, 8'h10, 16'd10, 8'h02, 32'hAABB_CCDD, 8'h00, 0, 1, 1, 32'hAABB_CCDD);
        add(3'h3, 8'h03, 16'd10, 8'h02, 0, 8'h00, 32'hCCDD_AABB, 0, 0, 0);
        add(3'h3, 8'h06, 16'd11, 8'h01, 32'h1111, 8'h00, 0, 1, 1, 32'hAABB_CCDD);
        add(3'h3, 8'h06, 16'd10, 8'h01, 32'h2222, 8'h00, 0, 1, 1, 32'h1111_2222);
        add(3'h2, 8'h06, 16'd30, 8'h01, 32'h9999, 8'h00, 0, 1, 3, 32'h0);
        add(3'h2, 8'h06, 16'd40, 8'h01, 32'h8888, 8'h00, 0, 1, 3, 32'h0);
        add(3'h2, 8'h06, 16'd31, 8'h01, 32'h7777, 8'h00, 0, 1, 3, 32'h0);
        add(3'h2, 8'h06, 16'd50, 8'h01, 32'hAAAA, 8'h00, 0, 0, 0, 0);
        add(3'h2, 8'h06, 16'd50, 8'h01, 32'hBBBB, 8'h00, 0, 1, 5, 32'h0);
        add(3'h2, 8'h06, 16'd51, 8'h01, 32'hCCCC, 8'h00, 0, 1, 5, 32'hBBBB_CCCC);
        add(3'h2, 8'h06, 16'd60, 8'h01, 32'h0001, 8'h00, 0, 0, 0, 0);
        add(3'h2, 8'h10, 16'd61, 8'h01, 32'h0002, 8'h00, 0, 1, 6, 32'h0);
        add(3'h2, 8'h06, 16'd100, 8'h01, 32'h0001, 8'h00, 0, 0, 0, 0);
        add(3'h2, 8'h05, 16'd101, 8'h01, 0, 8'h01, 0, 0, 0, 0);
        add(3'h2, 8'h06, 16'd101, 8'h01, 32'h0002, 8'h00, 0, 1, 10, 32'h0);
        add(3'h6, 8'h06, 16'd70, 8'h01, 32'h8001, 8'h00, 0, 1, 7, 32'h0000_8001);
        add(3'h4, 8'h06, 16'd80, 8'h01, 32'h8001, 8'h00, 0, 1, 8, 32'hFFFF_8001);
        add(3'h4, 8'h03, 16'd80, 8'h01, 0, 8'h00, 32'h8001, 0, 0, 0);
        add(3'h4, 8'h04, 16'd20, 8'h01, 0, 8'h00, 32'hC002, 0, 0, 0);
        add(3'h4, 8'h10, 16'd90, 8'h01, 32'h0042, 8'h00, 0, 1, 9, 32'h0000_0042);
        add(3'h4, 8'h03, 16'd81, 8'h01, 0, 8'h02, 0, 0, 0, 0);
        add(3'h2, 8'h03, 16'd11, 8'h02, 0, 8'h02, 0, 0, 0, 0);
        add(3'h2, 8'h03, 16'd160, 8'h01, 0, 8'h02, 0, 0, 0, 0);
        add(3'h2, 8'h03, 16'd12, 8'h01, 0, 8'h02, 0, 0, 0, 0);
        add(3'h2, 8'h03, 16'd0, 8'h03, 0, 8'h03, 0, 0, 0, 0);
        add(3'h2, 8'h03, 16'd0, 8'h00, 0, 8'h03, 0, 0, 0, 0);
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        check(user_vars[0], 32'h0, "reset var");
        check({rx_line, rs485_tx_pin, rs485_de}, 3'b110, "reset pins");
        $display("test reset done");
        foreach (rows[k]) begin
            @(posedge mclk);
            cfg <= msw_pkg::msw_cfg_s'(rows[k].cf);
            msw_master_model_i.send('{1'b1, rows[k].fc, rows[k].ad, rows[k].qt, rows[k].wd}, ans);
            check(ans.valid, 1'b1, "answer valid");
            check(ans.exception, rows[k].ex, "exception");
            check(ans.quantity, (rows[k].fc == 8'h06) ? 8'h01 : rows[k].qt, "quantity");
            if (rows[k].ex == 8'h00 && (rows[k].fc == 8'h03 || rows[k].fc == 8'h04)) begin
                check(ans.rdata, rows[k].rd, "read data");
            end
            if (rows[k].ck) begin
                check(user_vars[rows[k].ix], rows[k].vv, "stored var");
            end
        end
        $display("test rows done");
        // display changes between halves; second half must still come from the snapshot
        @(posedge mclk);
        cfg <= msw_pkg::msw_cfg_s'(3'h2);
        ask(8'h04, 16'd30, 8'h01);
        check(ans.rdata, 32'hD003, "snapshot first");
        @(posedge mclk);
        display_values[3] <= 32'h1234_5678;
        ask(8'h04, 16'd31, 8'h01);
        check(ans.rdata, 32'hC003, "snapshot second");
        ask(8'h04, 16'd30, 8'h01);
        check(ans.rdata, 32'h1234, "fresh read");
        ask(8'h06, 16'd0, 8'h01);
        check(ans.exception, 8'h00, "holding half write");
        check(user_vars[0], 32'h1234_5678, "half staged only");
        check(user_vars[3], 32'h0, "display read only");
        $display("test snapshot done");
        msw_master_model_i.drive_line(1'b0);
        repeat (5) @(posedge mclk);
        check(rx_line, 1'b0, "rx sync");
        tx_line <= 1'b0;
        tx_active <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({rs485_de, bus_level}, 2'b10, "driver on");
        @(posedge mclk);
        tx_active <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({rs485_de, bus_level}, 2'b01, "driver off");
        $display("test pins done");
        @(posedge mclk);
        reset_n <= 1'b0;
        @(negedge mclk);
        check(user_vars[1], 32'h0, "mid-run reset");
        $display("test second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
